//--- dpps_pkg.sv
// Constants and types for the dual-port power state controller
package dpps_pkg;
	// ---------------------------------------------
	// Register map and fields
	// ---------------------------------------------
	localparam logic [7:0] ADDR_CFG1 = 8'h11;
	localparam logic [7:0] ADDR_CFG2 = 8'h12;
	localparam logic [7:0] ADDR_STAT1 = 8'h13;
	localparam logic [7:0] ADDR_STAT2 = 8'h14;
	localparam logic [7:0] ADDR_STATE = 8'h15;
	localparam int CFG_EN_BIT = 0;
	localparam int CFG_ENABLE_PIN_IGNORE_BIT_BIT = 1;
	localparam int CFG_AUTO_REC_BIT = 2;
	localparam int CFG_CYC_LSB = 4;
	localparam logic [7:0] CFG1_MASK = 8'h77;
	localparam logic [7:0] CFG2_MASK = 8'h01;
	localparam logic [7:0] CFG1_RST = 8'h24;
	// Fault status bit positions
	localparam int FLT_W = 7;
	localparam int FLT_TSD_HI = 0;
	localparam int FLT_OVC = 1;
	localparam int FLT_BUS_UV = 2;
	localparam int FLT_BACKV = 3;
	localparam int FLT_DISCH = 4;
	localparam int FLT_SRC_OV = 5;
	localparam int FLT_TSD_LO = 6;
	// ---------------------------------------------
	// Timing
	// ---------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int T_MS_NS = 1000000;
	localparam int MS_CYCLES = T_MS_NS / CLK_PERIOD_NS;
	localparam int MS_CNT_W = 17;
	localparam int T_CYC_BASE_MS = 15;
	localparam int T_CYC_STEP_MS = 5;
	localparam int T_IDLE_SLEEP_MS = 10;
	localparam int REC_CNT_W = 6;
	localparam int IDLE_CNT_W = 8;
	localparam logic [1:0] BOOT_SAMPLE = 2'h2;
	localparam int FIN_W = 14;
	// ---------------------------------------------
	// Enumerations and state
	// ---------------------------------------------
	typedef enum logic [1:0] {
		ST_SLEEP = 2'h0,
		ST_AWAKE = 2'h1,
		ST_ACTIVE = 2'h3,
		ST_ERROR = 2'h2
	} dpps_state_e;
	localparam logic [2:0] STRAP_22K = 3'h0;
	localparam logic [2:0] STRAP_27K = 3'h1;
	localparam logic [2:0] STRAP_33K = 3'h2;
	localparam logic [2:0] STRAP_120K = 3'h3;
	localparam logic [2:0] STRAP_150K = 3'h4;
	localparam logic [2:0] STRAP_VDD = 3'h5;
	localparam logic [1:0] ILIM_3A5 = 2'h0;
	localparam logic [1:0] ILIM_4A3 = 2'h1;
	localparam logic [1:0] ILIM_5A2 = 2'h2;
	typedef struct packed {
		logic [1:0] en_s1, en_s2, en_d, pwrup_en, sw_on, alert_oe, chan_err, ilim;
		logic smclk_s1, smclk_s2, smclk_d, strap_done, smbus_mode, act_low;
		logic [2:0] strap_s1, strap_s2;
		logic [FIN_W-1:0] flt_s1, flt_s2;
		logic [1:0] boot_cnt;
		logic [7:0] cfg1, cfg2, rdata;
		logic rvalid, ms_tick;
		logic [FLT_W-1:0] stat1, stat2;
		dpps_state_e state;
		logic [1:0][REC_CNT_W-1:0] rec_cnt;
		logic [MS_CNT_W-1:0] ms_cnt;
		logic [IDLE_CNT_W-1:0] idle_cnt;
	} dpps_regs_s;
	localparam dpps_regs_s REGS_RST = '{cfg1: CFG1_RST, state: ST_SLEEP, default: '0};
endpackage

//--- dpps_ctrl.sv
// Power state and fault controller for a dual USB port power switch
//
// Function
// - Port enable control is pin OR config enable bit at 11h/12h.
// - Supply below threshold holds all logic reset, switches open.
// - Sleep only when both controls disabled; any enable leaves Sleep unless source undervoltage.
// - Sleep opens both switches and releases both fault outputs.
// - In Sleep only single-byte accesses; block accesses are ignored.
// - First read in Sleep wakes device and returns zero.
// - Awake device returns to Sleep after idle interval if disabled.
// - Entering Active closes every enabled port switch.
// - No Active, no closed switch under source undervoltage or none enabled.
// - In Active only enabled ports on; others off and discharged.
// - Thermal high, overcurrent, bus UV, back-voltage, discharge, source OV cause Error.
// - Low thermal trip plus CC mode, enable rise or power-up enable cause Error.
// - Error opens the affected switch and asserts its fault output.
// - Fault handling is per channel; the other port may stay on.
// - Error is evaluated before Active in the same cycle.
// - Each detected fault is recorded in its channel status register.
// - Auto-recovery checks faults every cycle time; clear returns Active.
// - With auto-recovery, enables dropping in Error keep Error; Sleep follows once cleared.
// - Strap selects mode, enable polarity and current limit, six codes.
// - Stand-alone mode ignores register accesses; bus clock edges still reset the idle timer.
// - Fault outputs only pull low or release.
// - Strap sampled once after reset and held until next reset.
// - Recovery cycle time defaults to 25 ms, programmable 15 to 50 ms.
// - Pin-ignore bit in management mode uses register enable bits only.
module dpps_ctrl #(
	parameter int P_MS_CYCLES = dpps_pkg::MS_CYCLES,
	parameter int P_IDLE_MS = dpps_pkg::T_IDLE_SLEEP_MS
) (
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire logic i_port1_enable_in,
	input wire logic i_port2_enable_in,
	input wire logic i_smclk,
	input wire logic [2:0] i_mode_limit_strap,
	input wire logic i_tsd_high,
	input wire logic i_tsd_low,
	input wire logic i_source_overvoltage,
	input wire logic i_source_undervoltage_level,
	input wire logic [1:0] i_overcurrent_limit,
	input wire logic [1:0] i_port_cc_mode,
	input wire logic [1:0] i_port_bus_uv,
	input wire logic [1:0] i_port_back_voltage,
	input wire logic [1:0] i_port_discharge_err,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic i_reg_block,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	output logic [7:0] o_reg_rdata,
	output logic o_reg_rvalid,
	output logic [1:0] o_port_switch_on,
	output logic [1:0] o_port_discharge,
	output logic o_alert1_b_o,
	output logic o_alert1_b_oe,
	output logic o_alert2_b_o,
	output logic o_alert2_b_oe,
	output logic o_smbus_mode,
	output logic o_enable_active_low,
	output logic [1:0] o_port_current_limit,
	output dpps_pkg::dpps_state_e o_power_state
);
	import dpps_pkg::*;

	localparam logic [MS_CNT_W-1:0] MS_LAST = MS_CNT_W'(P_MS_CYCLES - 1);
	localparam logic [IDLE_CNT_W-1:0] IDLE_LAST = IDLE_CNT_W'(P_IDLE_MS);

	dpps_regs_s r, n;
	logic tsd_hi, tsd_lo, s_ov, s_uv;
	logic [1:0] ovc, ccm, buv, bkv, dis;
	logic [1:0] pin_act, en_bits, en_ctl, en_rise, lvl, lo_trip, det;
	logic enable_pin_ignore_bit, en_any, act_req, watch, acc_ok, activity, idle_done;
	logic [REC_CNT_W-1:0] cyc_last;

	// ---------------------------------------------
	// Decoded conditions
	// ---------------------------------------------
	// Synchronised detector outputs, unpacked
	assign {tsd_hi, tsd_lo, s_ov, s_uv, ovc, ccm, buv, bkv, dis} = r.flt_s2;
	assign enable_pin_ignore_bit = r.smbus_mode & r.cfg1[CFG_ENABLE_PIN_IGNORE_BIT_BIT];
	assign pin_act = r.en_s2 ^ {2{r.act_low}};
	assign en_bits = {r.cfg2[CFG_EN_BIT], r.cfg1[CFG_EN_BIT]};
	assign en_ctl = r.strap_done ? ((pin_act & ~{2{enable_pin_ignore_bit}}) | en_bits) : 2'b00;
	assign en_any = |en_ctl;
	assign en_rise = en_ctl & ~r.en_d;
	assign act_req = r.strap_done & en_any & ~s_uv;
	assign watch = act_req | (r.state == ST_ACTIVE) | (r.state == ST_ERROR);
	assign lvl = {2{tsd_hi | s_ov}} | ovc | buv | bkv | dis | ({2{tsd_lo}} & ccm);
	assign lo_trip = {2{tsd_lo}} & (ccm | en_rise | r.pwrup_en);
	assign det = {2{watch}} & (lvl | lo_trip);
	// bus only in SMBus mode; no block in Sleep
	assign acc_ok = r.smbus_mode & r.strap_done & ~(i_reg_block & (r.state == ST_SLEEP));
	assign activity = (acc_ok & (i_reg_rd | i_reg_wr)) | (r.smclk_s2 ^ r.smclk_d);
	assign idle_done = r.idle_cnt >= IDLE_LAST;
	// 15 ms plus 5 ms steps
	assign cyc_last = REC_CNT_W'(T_CYC_BASE_MS - 1)
		+ REC_CNT_W'(T_CYC_STEP_MS) * REC_CNT_W'(r.cfg1[CFG_CYC_LSB+:3]);

	// Fault cause bits of one channel
	function automatic logic [FLT_W-1:0] cause(input int ch);
		logic [FLT_W-1:0] c;
		c = '0;
		c[FLT_TSD_HI] = tsd_hi;
		c[FLT_OVC] = ovc[ch];
		c[FLT_BUS_UV] = buv[ch];
		c[FLT_BACKV] = bkv[ch];
		c[FLT_DISCH] = dis[ch];
		c[FLT_SRC_OV] = s_ov;
		c[FLT_TSD_LO] = lo_trip[ch];
		return c;
	endfunction

	// ---------------------------------------------
	// Next-state logic
	// ---------------------------------------------
	always_comb begin
		n = r;
		n.en_s1 = {i_port2_enable_in, i_port1_enable_in};
		n.en_s2 = r.en_s1;
		n.smclk_s1 = i_smclk;
		n.smclk_s2 = r.smclk_s1;
		n.smclk_d = r.smclk_s2;
		n.strap_s1 = i_mode_limit_strap;
		n.strap_s2 = r.strap_s1;
		n.flt_s1 = {i_tsd_high, i_tsd_low, i_source_overvoltage, i_source_undervoltage_level,
			i_overcurrent_limit, i_port_cc_mode, i_port_bus_uv, i_port_back_voltage,
			i_port_discharge_err};
		n.flt_s2 = r.flt_s1;
		n.en_d = en_ctl;
		n.rvalid = 1'b0;
		// Millisecond tick for the slow timers
		n.ms_tick = (r.ms_cnt == MS_LAST);
		n.ms_cnt = n.ms_tick ? '0 : r.ms_cnt + MS_CNT_W'(1);
		// strap caught once, after sync pipe fills
		n.pwrup_en = 2'b00;
		if (!r.strap_done) begin
			if (r.boot_cnt == BOOT_SAMPLE) begin
				n.strap_done = 1'b1;
				case (r.strap_s2)
					STRAP_22K: {n.smbus_mode, n.act_low, n.ilim} = {2'b10, ILIM_3A5};
					STRAP_27K: {n.smbus_mode, n.act_low, n.ilim} = {2'b10, ILIM_4A3};
					STRAP_33K: {n.smbus_mode, n.act_low, n.ilim} = {2'b10, ILIM_5A2};
					STRAP_120K: {n.smbus_mode, n.act_low, n.ilim} = {2'b01, ILIM_3A5};
					STRAP_150K: {n.smbus_mode, n.act_low, n.ilim} = {2'b01, ILIM_4A3};
					STRAP_VDD: {n.smbus_mode, n.act_low, n.ilim} = {2'b01, ILIM_5A2};
					default: {n.smbus_mode, n.act_low, n.ilim} = {2'b10, ILIM_3A5};
				endcase
				n.pwrup_en = r.en_s2 ^ {2{n.act_low}};
			end else begin
				n.boot_cnt = r.boot_cnt + 2'h1;
			end
		end
		// Register reads; status clears on read, new fault set wins
		if (acc_ok && i_reg_rd) begin
			n.rvalid = 1'b1;
			case (i_reg_addr)
				ADDR_CFG1: n.rdata = r.cfg1;
				ADDR_CFG2: n.rdata = r.cfg2;
				ADDR_STAT1: n.rdata = {1'b0, r.stat1};
				ADDR_STAT2: n.rdata = {1'b0, r.stat2};
				ADDR_STATE: n.rdata = {6'h00, r.state};
				default: n.rdata = 8'h00;
			endcase
			if (i_reg_addr == ADDR_STAT1) n.stat1 = '0;
			if (i_reg_addr == ADDR_STAT2) n.stat2 = '0;
			if (r.state == ST_SLEEP) n.rdata = 8'h00;
		end
		// Register writes, reserved bits kept at zero
		if (acc_ok && i_reg_wr) begin
			if (i_reg_addr == ADDR_CFG1) n.cfg1 = i_reg_wdata & CFG1_MASK;
			if (i_reg_addr == ADDR_CFG2) n.cfg2 = i_reg_wdata & CFG2_MASK;
		end
		if (det[0]) n.stat1 = n.stat1 | cause(0);
		if (det[1]) n.stat2 = n.stat2 | cause(1);
		// Per-channel fault handling
		for (int i = 0; i < 2; i++) begin
			if (r.chan_err[i]) begin
				if (r.ms_tick) begin
					n.rec_cnt[i] = r.rec_cnt[i] + REC_CNT_W'(1);
					// check all causes each cycle time
					if (r.rec_cnt[i] == cyc_last) begin
						n.rec_cnt[i] = '0;
						// A cause seen in the check cycle itself keeps the channel faulted
						if (r.cfg1[CFG_AUTO_REC_BIT] && !det[i]) n.chan_err[i] = 1'b0;
					end
				end
				// Latched handling: released by dropping the enable
				if (!r.cfg1[CFG_AUTO_REC_BIT] && !en_ctl[i] && !det[i]) begin
					n.chan_err[i] = 1'b0;
				end
			end else if (det[i]) begin
				n.chan_err[i] = 1'b1;
				n.rec_cnt[i] = '0;
			end
		end
		// Idle timer for the return to Sleep
		if (activity) begin
			n.idle_cnt = '0;
		end else if (r.ms_tick && !idle_done) begin
			n.idle_cnt = r.idle_cnt + IDLE_CNT_W'(1);
		end
		if (!r.strap_done) begin
			n.state = ST_SLEEP;
		end else if (|n.chan_err) begin
			n.state = ST_ERROR;
		end else if (act_req) begin
			n.state = ST_ACTIVE;
		end else begin
			case (r.state)
				ST_SLEEP: n.state = (acc_ok && i_reg_rd) ? ST_AWAKE : ST_SLEEP;
				ST_AWAKE: n.state = (idle_done && !en_any) ? ST_SLEEP : ST_AWAKE;
				default: n.state = en_any ? ST_AWAKE : ST_SLEEP;
			endcase
		end
		n.sw_on = ((n.state == ST_ACTIVE) || (n.state == ST_ERROR)) && !s_uv ?
			en_ctl & ~n.chan_err : 2'b00;
		n.alert_oe = (n.state == ST_SLEEP) ? 2'b00 : n.chan_err;
	end

	// State register; supply reset loads REGS_RST, cfg1 to 24h and all else cleared
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			r <= REGS_RST;
		end else begin
			r <= n;
		end
	end

	// ---------------------------------------------
	// Outputs
	// ---------------------------------------------
	assign o_reg_rdata = r.rdata;
	assign o_reg_rvalid = r.rvalid;
	assign o_port_switch_on = r.sw_on;
	// Disabled outputs are pulled toward ground
	assign o_port_discharge = ~r.sw_on;
	assign o_alert1_b_o = 1'b0;
	assign o_alert2_b_o = 1'b0;
	assign o_alert1_b_oe = r.alert_oe[0];
	assign o_alert2_b_oe = r.alert_oe[1];
	assign o_smbus_mode = r.smbus_mode;
	assign o_enable_active_low = r.act_low;
	assign o_port_current_limit = r.ilim;
	assign o_power_state = r.state;

	// ---------------------------------------------
	// Assertions
	// ---------------------------------------------
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_b);

	sequence s_sleep_read;
		r.state == ST_SLEEP && acc_ok && i_reg_rd && !act_req && det == 2'b00;
	endsequence

	sequence s_woken;
		r.rvalid && r.rdata == 8'h00 && r.state == ST_AWAKE;
	endsequence

	en_bit_act_a: assert property (
		$rose(r.cfg1[CFG_EN_BIT]) && r.strap_done && !s_uv && det == 2'b00
		&& r.chan_err == 2'b00 |=> r.state == ST_ACTIVE)
		else $error("enable bit did not start Active");
	sleep_entry_a: assert property (
		r.state == ST_SLEEP && $past(r.state) != ST_SLEEP && $past(r.strap_done)
		|-> $past(!en_any))
		else $error("Sleep entered while enabled");
	sleep_quiet_a: assert property (
		r.state == ST_SLEEP |-> r.sw_on == 2'b00 && r.alert_oe == 2'b00)
		else $error("switch or alert active in Sleep");
	block_sleep_a: assert property (
		r.state == ST_SLEEP && i_reg_block && i_reg_wr |=> r.cfg1 == $past(r.cfg1))
		else $error("block write taken in Sleep");
	wake_read_a: assert property (
		s_sleep_read |=> s_woken)
		else $error("dummy read did not wake with zero");
	idle_sleep_a: assert property (
		r.state == ST_AWAKE && idle_done && !en_any && !activity && det == 2'b00
		|=> r.state == ST_SLEEP)
		else $error("no return to Sleep after idle");
	active_close_a: assert property (
		$rose(r.state == ST_ACTIVE) |-> r.sw_on == $past(en_ctl))
		else $error("enabled switch not closed on Active");
	switch_guard_a: assert property (
		r.sw_on != 2'b00 |-> $past(en_any && !s_uv) && (r.sw_on & ~$past(en_ctl)) == 2'b00)
		else $error("switch closed while not allowed");
	err_open_a: assert property (
		r.chan_err[0] && r.state != ST_SLEEP |-> !r.sw_on[0] && r.alert_oe[0])
		else $error("faulted port not opened and flagged");
	other_port_a: assert property (
		r.chan_err == 2'b01 && !det[1] && en_ctl[1] && !s_uv |=> r.sw_on[1])
		else $error("healthy port dropped by other fault");
	err_prio_a: assert property (
		r.strap_done && act_req && det != 2'b00 |=> r.state == ST_ERROR)
		else $error("Active chosen over Error");
	stat_rec_a: assert property (
		det[0] && ovc[0] |=> r.stat1[FLT_OVC])
		else $error("overcurrent not recorded");
	recover_a: assert property (
		$fell(r.chan_err[0]) && $past(r.cfg1[CFG_AUTO_REC_BIT])
		|-> $past(r.ms_tick && !lvl[0] && r.rec_cnt[0] == cyc_last))
		else $error("recovery outside cycle check");
	err_hold_a: assert property (
		r.state == ST_ERROR && !en_any |=> r.state != ST_ACTIVE)
		else $error("Error left for Active while disabled");
	strap_hold_a: assert property (
		r.strap_done |=> $stable({r.smbus_mode, r.act_low, r.ilim}))
		else $error("strap decode changed");
	standalone_a: assert property (
		!r.smbus_mode && (i_reg_wr || i_reg_rd) |=> r.cfg1 == $past(r.cfg1) && !r.rvalid)
		else $error("bus access taken in stand-alone mode");
	pin_sync_a: assert property (
		$rose(r.en_s2[0]) |-> $past(i_port1_enable_in, 2))
		else $error("enable pin not passed through two flops");
	port_fault_a: assert property (
		watch && lvl[1] |=> r.chan_err[1])
		else $error("port 2 fault did not raise Error");
	lo_trip_a: assert property (
		watch && lo_trip[0] |=> r.chan_err[0])
		else $error("low thermal trip did not raise Error");
	pin_ignore_a: assert property (
		enable_pin_ignore_bit |=> (r.sw_on & ~$past(en_bits)) == 2'b00)
		else $error("enable pin used while ignored");
	stat2_rec_a: assert property (
		det[1] && bkv[1] |=> r.stat2[FLT_BACKV])
		else $error("port 2 back-voltage not recorded");
endmodule // dpps_ctrl

//--- dpps_host_model.sv
// Host controller model: enable pins, bus clock frames, byte strobes, pull-ups
module dpps_host_model (
	input wire logic i_mclk,
	input wire logic i_alert1_b_o,
	input wire logic i_alert1_b_oe,
	input wire logic i_alert2_b_o,
	input wire logic i_alert2_b_oe,
	input wire logic i_reg_rvalid,
	input wire logic [7:0] i_reg_rdata,
	output logic [1:0] o_enable_in,
	output logic o_smclk,
	output logic o_reg_wr,
	output logic o_reg_rd,
	output logic o_reg_block,
	output logic [7:0] o_reg_addr,
	output logic [7:0] o_reg_wdata,
	output logic [1:0] o_alert_lvl
);
	timeunit 1ns;
	timeprecision 100ps;
	// ---------------------------------------------
	// Pins and byte accesses
	// ---------------------------------------------
	// pull-up defines released level
	assign o_alert_lvl = {i_alert2_b_oe ? i_alert2_b_o : 1'b1,
		i_alert1_b_oe ? i_alert1_b_o : 1'b1};
	// Idle bus, clock held high between frames
	initial begin
		o_enable_in = 2'b00;
		o_smclk = 1'b1;
		o_reg_wr = 1'b0;
		o_reg_rd = 1'b0;
		o_reg_block = 1'b0;
		o_reg_addr = 8'h00;
		o_reg_wdata = 8'h00;
	end
	task automatic set_pins(input logic [1:0] v);
		o_enable_in = v;
	endtask
	// One byte frame; bus clock edges on the core clock's falling edge
	task automatic access(input logic rd, input logic blk, input logic [7:0] a,
		input logic [7:0] d, output logic got, output logic [7:0] q);
		// Edges 80 ns apart, so the idle timer never spans a whole interval in a frame
		repeat (4) begin
			o_smclk = ~o_smclk;
			repeat (8) @(negedge i_mclk);
		end
		@(negedge i_mclk);
		o_reg_rd = rd;
		o_reg_wr = ~rd;
		// block flag only when a scenario asks
		o_reg_block = blk;
		o_reg_addr = a;
		o_reg_wdata = d;
		@(negedge i_mclk);
		o_reg_rd = 1'b0;
		o_reg_wr = 1'b0;
		o_reg_block = 1'b0;
		// Released bus shows the inverse, not the old value
		o_reg_addr = ~a;
		o_reg_wdata = ~d;
		got = i_reg_rvalid;
		q = i_reg_rdata;
		@(negedge i_mclk);
		got = got | i_reg_rvalid;
		if (i_reg_rvalid) begin
			q = i_reg_rdata;
		end
	endtask
endmodule // dpps_host_model

//--- tb_dual_port_power_state_control.sv
// Self-checking bench for the dual-port power state controller
`define CHK(nm, e, g) begin \
	n_checks++; \
	if ((g) !== (e)) begin \
		failures++; \
		$display("CHECK FAILED %s exp %h got %h", nm, e, g); \
	end \
end
module tb_dual_port_power_state_control;
	timeunit 1ns;
	timeprecision 100ps;
	import dpps_pkg::*;
	// ---------------------------------------------
	// Signals, strap table, instances
	// ---------------------------------------------
	typedef struct packed {
		logic [2:0] strap;
		logic sm;
		logic al;
		logic [1:0] il;
	} dpps_row_s;
	dpps_row_s rows [6] = '{'{STRAP_22K, 1'b1, 1'b0, ILIM_3A5},
		'{STRAP_27K, 1'b1, 1'b0, ILIM_4A3}, '{STRAP_33K, 1'b1, 1'b0, ILIM_5A2},
		'{STRAP_120K, 1'b0, 1'b1, ILIM_3A5}, '{STRAP_150K, 1'b0, 1'b1, ILIM_4A3},
		'{STRAP_VDD, 1'b0, 1'b1, ILIM_5A2}};
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [2:0] strap = 3'h0;
	logic [5:0] flt = 6'h00;
	logic [4:1] flt2 = 4'h0;
	logic tsd_low = 1'b0;
	logic uv = 1'b0;
	logic [1:0] cc = 2'h0;
	logic got, glob, smode, actlow, wr_s, rd_s, blk, smclk, o1, oe1, o2, oe2, rvalid;
	logic [7:0] q, rdata, addr, wdata;
	logic [1:0] sw, dis, ilim, pins, alert;
	dpps_state_e st;
	int failures = 0;
	int n_checks = 0;
	// Short ms tick keeps recovery at 250 cycles
	dpps_ctrl #(.P_MS_CYCLES(10), .P_IDLE_MS(2)) dut (
		.i_mclk(clk), .i_rst_b(rst_b), .i_port1_enable_in(pins[0]),
		.i_port2_enable_in(pins[1]), .i_smclk(smclk), .i_mode_limit_strap(strap),
		.i_tsd_high(flt[0]), .i_tsd_low(tsd_low), .i_source_overvoltage(flt[5]),
		.i_source_undervoltage_level(uv), .i_overcurrent_limit({flt2[1], flt[1]}),
		.i_port_cc_mode(cc), .i_port_bus_uv({flt2[2], flt[2]}),
		.i_port_back_voltage({flt2[3], flt[3]}), .i_port_discharge_err({flt2[4], flt[4]}),
		.i_reg_wr(wr_s), .i_reg_rd(rd_s), .i_reg_block(blk), .i_reg_addr(addr),
		.i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
		.o_port_switch_on(sw), .o_port_discharge(dis), .o_alert1_b_o(o1),
		.o_alert1_b_oe(oe1), .o_alert2_b_o(o2), .o_alert2_b_oe(oe2),
		.o_smbus_mode(smode), .o_enable_active_low(actlow),
		.o_port_current_limit(ilim), .o_power_state(st)
	);
	dpps_host_model host (
		.i_mclk(clk), .i_alert1_b_o(o1), .i_alert1_b_oe(oe1), .i_alert2_b_o(o2),
		.i_alert2_b_oe(oe2), .i_reg_rvalid(rvalid), .i_reg_rdata(rdata),
		.o_enable_in(pins), .o_smclk(smclk), .o_reg_wr(wr_s), .o_reg_rd(rd_s),
		.o_reg_block(blk), .o_reg_addr(addr), .o_reg_wdata(wdata), .o_alert_lvl(alert)
	);
	always #5 clk = ~clk;
	// ---------------------------------------------
	// Helpers
	// ---------------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	// Strap and pins settle before release; strap is sampled after it
	task automatic do_reset(input logic [2:0] s, input logic [1:0] p);
		rst_b = 1'b0;
		strap = s;
		host.set_pins(p);
		cyc(20);
		rst_b = 1'b1;
		cyc(6);
	endtask
	task automatic rd(input logic [7:0] a, input logic b);
		host.access(1'b1, b, a, 8'h00, got, q);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		host.access(1'b0, 1'b0, a, d, got, q);
	endtask
	task automatic finish_test();
		if (failures == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Watchdog well beyond the expected few thousand cycles
	initial begin
		#(60000 * 10);
		failures++;
		finish_test();
	end
	// ---------------------------------------------
	// Main sequence
	// ---------------------------------------------
	initial begin
		cyc(5);
		`CHK("rst_sw", 2'b00, sw)
		`CHK("rst_dis", 2'b11, dis)
		`CHK("rst_oe", 2'b00, {oe2, oe1})
		`CHK("rst_st", ST_SLEEP, st)
		// Strap table; strap moved after sampling must not matter
		foreach (rows[i]) begin
			do_reset(rows[i].strap, rows[i].al ? 2'b11 : 2'b00);
			strap = ~rows[i].strap;
			cyc(3);
			`CHK("mode", rows[i].sm, smode)
			`CHK("pol", rows[i].al, actlow)
			`CHK("ilim", rows[i].il, ilim)
		end
		// Stand-alone, active-low pins
		host.set_pins(2'b10);
		cyc(8);
		`CHK("sa_sw", 2'b01, sw)
		rd(ADDR_CFG1, 1'b0);
		`CHK("sa_bus", 1'b0, got)
		wr(ADDR_CFG2, 8'h01);
		cyc(8);
		`CHK("sa_wr", 2'b01, sw)
		do_reset(STRAP_22K, 2'b00);
		// Block write in Sleep must leave cfg2 at zero
		host.access(1'b0, 1'b1, ADDR_CFG2, 8'h01, got, q);
		rd(ADDR_CFG1, 1'b1);
		`CHK("blk", 1'b0, got)
		`CHK("blk_st", ST_SLEEP, st)
		rd(ADDR_CFG1, 1'b0);
		`CHK("dummy", 8'h00, q)
		`CHK("wake", ST_AWAKE, st)
		rd(ADDR_CFG1, 1'b0);
		`CHK("cfg1", CFG1_RST, q)
		rd(ADDR_CFG2, 1'b0);
		`CHK("cfg2", 8'h00, q)
		rd(8'h30, 1'b0);
		`CHK("unmap", 8'h00, q)
		cyc(50);
		`CHK("idle", ST_SLEEP, st)
		rd(ADDR_STATE, 1'b0);
		wr(ADDR_CFG1, 8'h25);
		cyc(8);
		`CHK("one_sw", 2'b01, sw)
		`CHK("one_dis", 2'b10, dis)
		wr(ADDR_CFG2, 8'h01);
		cyc(8);
		`CHK("two_sw", 2'b11, sw)
		// Each fault source, then auto-recovery after the cycle time
		for (int k = 0; k < 6; k++) begin
			glob = (k == 0) || (k == 5);
			flt[k] = 1'b1;
			cyc(8);
			`CHK("err_st", ST_ERROR, st)
			`CHK("err_sw", {~glob, 1'b0}, sw)
			`CHK("err_alert", {~glob, 1'b0}, alert)
			rd(ADDR_STAT1, 1'b0);
			`CHK("stat", 1'b1, q[k])
			flt[k] = 1'b0;
			cyc(180);
			`CHK("rec_early", ST_ERROR, st)
			cyc(120);
			`CHK("rec_st", ST_ACTIVE, st)
			`CHK("rec_alert", 2'b11, alert)
		end
		uv = 1'b1;
		cyc(8);
		`CHK("uv_sw", 2'b00, sw)
		`CHK("uv_st", 1'b0, st === ST_ACTIVE)
		uv = 1'b0;
		cyc(300);
		`CHK("uv_back", 2'b11, sw)
		wr(ADDR_CFG1, 8'h24);
		wr(ADDR_CFG2, 8'h00);
		cyc(50);
		`CHK("off_st", ST_SLEEP, st)
		// Fault and enable arrive together
		flt[1] = 1'b1;
		host.set_pins(2'b01);
		cyc(8);
		`CHK("prio", ST_ERROR, st)
		host.set_pins(2'b00);
		cyc(20);
		`CHK("err_hold", ST_ERROR, st)
		flt[1] = 1'b0;
		cyc(300);
		`CHK("err_sleep", ST_SLEEP, st)
		`CHK("slp_alert", 2'b11, alert)
		tsd_low = 1'b1;
		host.set_pins(2'b01);
		cyc(8);
		`CHK("lo_trip", ST_ERROR, st)
		rd(ADDR_STAT1, 1'b0);
		`CHK("lo_stat", 1'b1, q[FLT_TSD_LO])
		tsd_low = 1'b0;
		host.set_pins(2'b00);
		cyc(300);
		rd(ADDR_STATE, 1'b0);
		// Port 2 faults alone: port 1 keeps its switch
		wr(ADDR_CFG1, 8'h25);
		wr(ADDR_CFG2, 8'h01);
		cyc(8);
		tsd_low = 1'b1;
		cc = 2'b10;
		cyc(8);
		`CHK("cc_sw", 2'b01, sw)
		`CHK("cc_alert", 2'b01, alert)
		rd(ADDR_STAT2, 1'b0);
		`CHK("cc_stat", 1'b1, q[FLT_TSD_LO])
		tsd_low = 1'b0;
		cc = 2'b00;
		for (int k = 1; k < 5; k++) begin
			flt2[k] = 1'b1;
			rd(ADDR_STAT2, 1'b0);
			`CHK("stat2", 1'b1, q[k])
			flt2[k] = 1'b0;
		end
		cyc(300);
		`CHK("p2_rec", 2'b11, sw)
		wr(ADDR_CFG2, 8'h00);
		wr(ADDR_CFG1, 8'h26);
		host.set_pins(2'b01);
		cyc(8);
		`CHK("enable_pin_ignore_bit", 2'b00, sw)
		// Latched handling: held until the enable drops
		host.set_pins(2'b00);
		wr(ADDR_CFG1, 8'h21);
		flt[2] = 1'b1;
		cyc(8);
		flt[2] = 1'b0;
		cyc(300);
		`CHK("latch_hold", ST_ERROR, st)
		wr(ADDR_CFG1, 8'h20);
		cyc(8);
		`CHK("latch_rel", ST_SLEEP, st)
		finish_test();
	end
endmodule // tb_dual_port_power_state_control
